// ---- hw/tscn_notifier.sv ----
// touch switch change notifier: builds and sends the change frame byte by byte
// Operation
// - any touch switch bit change, press or release, sends one notification frame
// - ordinarily a frame reports the change of one allocated bit
// - bits of one word changing together go out in one frame
// - screen change with no release already pending clears held momentary bits and notifies that change
// - frame opens with escape byte then ASCII S and T
// - changed word number follows as four ASCII hex digits
// - new 16-bit word contents follow as four ASCII hex digits
// - changed-bit mask follows as four ASCII hex digits
// - one-byte checksum follows as two ASCII hex digits
// - a single carriage return ends every frame
`timescale 1ns/100ps
`include "tscn_consts.svh"
module tscn_notifier (
	input wire logic clk,
	input wire logic reset,
	input wire logic ev_valid,
	input wire logic [15:0] ev_word,
	input wire logic [15:0] ev_value,
	input wire logic [15:0] ev_mask,
	output logic ev_ready_q,
	input wire logic scr_change,
	input wire logic [15:0] mom_word,
	input wire logic [15:0] mom_value,
	input wire logic [15:0] mom_held,
	output logic mom_clr_q,
	output logic [15:0] mom_clr_word_q,
	output logic [15:0] mom_clr_mask_q,
	output logic tx_valid_q,
	output logic [7:0] tx_data_q,
	input wire logic tx_ready,
	output logic busy_q
);
	tscn_pkg::tscn_state_t state_q, state_d;
	tscn_pkg::tscn_idx_t idx_q, idx_d, sel_idx;
	logic [15:0] word_q, word_d, value_q, value_d, mask_q, mask_d;
	logic [15:0] pw_q, pv_q, pm_q;
	logic pend_q, pend_d;
	logic [7:0] csum_q, csum_d, tx_data_d, sel_byte;
	logic tx_valid_d, ev_ready_d;

	wire is_idle = state_q == tscn_pkg::TSCN_IDLE;
	wire ev_take = ev_valid & ev_ready_q;
	// a zero mask carries no change, so it is taken and dropped
	wire start_ev = is_idle & ev_take & (ev_mask != 16'h0000);
	wire [15:0] mom_chg = mom_value & mom_held;
	// only one momentary release can wait; a second screen change while one
	// is pending finds those bits already cleared
	wire mom_take = scr_change & (mom_chg != 16'h0000) & ~pend_q;
	wire start_mom = is_idle & ~ev_take & pend_q;
	wire start = start_ev | start_mom;
	wire tx_fire = tx_valid_q & tx_ready;
	wire is_last = idx_q == `TSCN_IDX_LAST;
	wire load = start | (tx_fire & ~is_last);

	assign sel_idx = start ? 5'h00 : 5'(idx_q + 5'h01);
	assign pend_d = mom_take | (pend_q & ~start_mom);
	assign idx_d = start ? 5'h00 : (tx_fire ? 5'(idx_q + 5'h01) : idx_q);
	assign word_d = start_ev ? ev_word : (start_mom ? pw_q : word_q);
	assign value_d = start_ev ? ev_value : (start_mom ? pv_q : value_q);
	assign mask_d = start_ev ? ev_mask : (start_mom ? pm_q : mask_q);
	assign tx_valid_d = load | (tx_valid_q & ~tx_fire);
	assign tx_data_d = load ? sel_byte : tx_data_q;
	// running sum over bytes before the checksum digits
	assign csum_d = start ? sel_byte :
		((load & (sel_idx < `TSCN_IDX_CSUM)) ? 8'(csum_q + sel_byte) : csum_q);
	assign ev_ready_d = (state_d == tscn_pkg::TSCN_IDLE) & ~pend_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			tscn_pkg::TSCN_IDLE: begin
				if (start) begin
					state_d = tscn_pkg::TSCN_SEND;
				end
			end
			tscn_pkg::TSCN_SEND: begin
				if (tx_fire & is_last) begin
					state_d = tscn_pkg::TSCN_IDLE;
				end
			end
		endcase
	end

	tscn_byte_sel u_sel (
		.idx(sel_idx),
		.word(word_d),
		.value(value_d),
		.mask(mask_d),
		.csum(csum_q),
		.frame_byte(sel_byte)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= tscn_pkg::TSCN_IDLE;
			idx_q <= 5'h00;
			word_q <= 16'h0000;
			value_q <= 16'h0000;
			mask_q <= 16'h0000;
			csum_q <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			ev_ready_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			word_q <= word_d;
			value_q <= value_d;
			mask_q <= mask_d;
			csum_q <= csum_d;
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
			ev_ready_q <= ev_ready_d;
			busy_q <= state_d == tscn_pkg::TSCN_SEND;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pend_q <= 1'b0;
			pw_q <= 16'h0000;
			pv_q <= 16'h0000;
			pm_q <= 16'h0000;
			mom_clr_q <= 1'b0;
			mom_clr_word_q <= 16'h0000;
			mom_clr_mask_q <= 16'h0000;
		end else begin
			pend_q <= pend_d;
			mom_clr_q <= mom_take;
			if (mom_take) begin
				pw_q <= mom_word;
				pv_q <= mom_value & ~mom_held;
				pm_q <= mom_chg;
				mom_clr_word_q <= mom_word;
				mom_clr_mask_q <= mom_chg;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// helper count of accepted bytes, kept apart from the frame index
	logic [4:0] fire_cnt_q;
	always_ff @(posedge clk) begin
		if (reset | start) begin
			fire_cnt_q <= 5'h00;
		end else if (tx_fire) begin
			fire_cnt_q <= 5'(fire_cnt_q + 5'h01);
		end
	end

	chk_frame_esc: assert property (start |=> tx_valid_q && tx_data_q == `TSCN_BYTE_ESC)
		else $error("frame does not open with escape");
	chk_cmd_first: assert property (tx_fire && idx_q == 5'h00 |=>
		tx_data_q == `TSCN_BYTE_S)
		else $error("first command letter wrong");
	chk_cmd_second: assert property (tx_fire && idx_q == 5'h01 |=>
		tx_data_q == `TSCN_BYTE_T)
		else $error("second command letter wrong");
	chk_word_digit: assert property (tx_fire && idx_q == 5'h02 |=>
		tx_data_q == tscn_pkg::tscn_hex(word_q[15:12]))
		else $error("word number digit wrong");
	chk_word_low: assert property (tx_fire && idx_q == 5'h05 |=>
		tx_data_q == tscn_pkg::tscn_hex(word_q[3:0]))
		else $error("word number low digit wrong");
	chk_value_digit: assert property (tx_fire && idx_q == 5'h06 |=>
		tx_data_q == tscn_pkg::tscn_hex(value_q[15:12]))
		else $error("word contents digit wrong");
	chk_value_low: assert property (tx_fire && idx_q == 5'h09 |=>
		tx_data_q == tscn_pkg::tscn_hex(value_q[3:0]))
		else $error("word contents low digit wrong");
	chk_mask_high: assert property (tx_fire && idx_q == 5'h0a |=>
		tx_data_q == tscn_pkg::tscn_hex(mask_q[15:12]))
		else $error("mask high digit wrong");
	chk_mask_digit: assert property (tx_fire && idx_q == 5'h0d |=>
		tx_data_q == tscn_pkg::tscn_hex(mask_q[3:0]))
		else $error("mask digit wrong");
	chk_csum_high: assert property (tx_fire && idx_q == 5'h0e |=>
		tx_data_q == tscn_pkg::tscn_hex(csum_q[7:4]))
		else $error("checksum digit wrong");
	chk_csum_low: assert property (tx_fire && idx_q == 5'h0f |=>
		tx_data_q == tscn_pkg::tscn_hex(csum_q[3:0]))
		else $error("checksum low digit wrong");
	chk_frame_cr: assert property (tx_valid_q && is_last |-> tx_data_q == `TSCN_BYTE_CR)
		else $error("frame not ended by carriage return");
	chk_frame_len: assert property (tx_fire && is_last |->
		fire_cnt_q == `TSCN_IDX_LAST)
		else $error("frame length wrong");
	// a sink may stall on any byte, so the byte must not move under it
	chk_tx_hold: assert property (tx_valid_q && !tx_ready |=>
		tx_valid_q && $stable(tx_data_q))
		else $error("byte changed while stalled");
	chk_idle_quiet: assert property (!busy_q |-> !tx_valid_q)
		else $error("byte offered outside a frame");
	chk_mask_nonzero: assert property (busy_q |-> mask_q != 16'h0000)
		else $error("frame without a changed bit");
	chk_event_mask: assert property (start_ev |=> busy_q && mask_q == $past(ev_mask))
		else $error("event mask not carried");
	chk_ready_return: assert property (tx_fire && is_last && !pend_q && !mom_take |=>
		ev_ready_q && !busy_q)
		else $error("not ready after frame");
	chk_mom_clear: assert property (mom_take |=>
		mom_clr_q && mom_clr_mask_q == $past(mom_chg) && pend_q)
		else $error("momentary clear missing");
	chk_mom_word: assert property (mom_take |=> mom_clr_word_q == $past(mom_word))
		else $error("momentary clear word wrong");
	chk_mom_pulse: assert property (mom_clr_q |=> !mom_clr_q)
		else $error("momentary clear longer than one cycle");
	chk_mom_frame: assert property (start_mom |=>
		value_q == $past(pv_q) && mask_q == $past(pm_q) && !pend_q)
		else $error("momentary frame fields wrong");
	chk_pend_block: assert property (pend_q |-> !ev_ready_q)
		else $error("event taken while release waits");
	chk_no_overlap: assert property (busy_q |-> !ev_ready_q)
		else $error("event taken during frame");
	cov_event_frame: cover property (start_ev ##1 busy_q);
	cov_mom_frame: cover property (start_mom);
	cov_frame_end: cover property (tx_fire && is_last);
	cov_stall: cover property (tx_valid_q && !tx_ready ##1 tx_fire);
	cov_mom_wait: cover property (mom_take && !is_idle);
endmodule : tscn_notifier

// ---- common/tscn_consts.svh ----
// constants for the touch switch change notifier
`ifndef TSCN_CONSTS_SVH
`define TSCN_CONSTS_SVH
`define TSCN_BYTE_ESC 8'h1b
`define TSCN_BYTE_S 8'h53
`define TSCN_BYTE_T 8'h54
`define TSCN_BYTE_CR 8'h0d
`define TSCN_IDX_WORD 5'h03
`define TSCN_IDX_VALUE 5'h07
`define TSCN_IDX_MASK 5'h0b
`define TSCN_IDX_CSUM 5'h0f
`define TSCN_IDX_LAST 5'h11
`define TSCN_ASCII_ZERO 8'h30
`define TSCN_ASCII_A_OFS 8'h37
`endif

// ---- common/tscn_pkg.sv ----
// types and helpers for the touch switch change notifier
`include "tscn_consts.svh"
package tscn_pkg;
	typedef enum logic {TSCN_IDLE, TSCN_SEND} tscn_state_t;
	typedef logic [4:0] tscn_idx_t;
	function automatic logic [7:0] tscn_hex(input logic [3:0] nib);
		logic [7:0] wide;
		wide = {4'h0, nib};
		if (nib < 4'ha) begin
			tscn_hex = wide + `TSCN_ASCII_ZERO;
		end else begin
			tscn_hex = wide + `TSCN_ASCII_A_OFS;
		end
	endfunction : tscn_hex
endpackage : tscn_pkg

// ---- hw/tscn_byte_sel.sv ----
// frame byte selector: byte value for a given position in the frame
`timescale 1ns/100ps
`include "tscn_consts.svh"
module tscn_byte_sel (
	input wire tscn_pkg::tscn_idx_t idx,
	input wire logic [15:0] word,
	input wire logic [15:0] value,
	input wire logic [15:0] mask,
	input wire logic [7:0] csum,
	output logic [7:0] frame_byte
);
	wire [4:0] rel_word = idx - `TSCN_IDX_WORD;
	wire [4:0] rel_value = idx - `TSCN_IDX_VALUE;
	wire [4:0] rel_mask = idx - `TSCN_IDX_MASK;
	wire [4:0] rel_csum = idx - `TSCN_IDX_CSUM;
	// digits go out most significant first
	wire [3:0] nib_word = word[4'(4'hc - {rel_word[1:0], 2'b00}) +: 4];
	wire [3:0] nib_value = value[4'(4'hc - {rel_value[1:0], 2'b00}) +: 4];
	wire [3:0] nib_mask = mask[4'(4'hc - {rel_mask[1:0], 2'b00}) +: 4];
	wire [3:0] nib_csum = rel_csum[0] ? csum[3:0] : csum[7:4];
	always_comb begin
		if (idx == 5'h00) begin
			frame_byte = `TSCN_BYTE_ESC;
		end else if (idx == 5'h01) begin
			frame_byte = `TSCN_BYTE_S;
		end else if (idx == 5'h02) begin
			frame_byte = `TSCN_BYTE_T;
		end else if (idx < `TSCN_IDX_VALUE) begin
			frame_byte = tscn_pkg::tscn_hex(nib_word);
		end else if (idx < `TSCN_IDX_MASK) begin
			frame_byte = tscn_pkg::tscn_hex(nib_value);
		end else if (idx < `TSCN_IDX_CSUM) begin
			frame_byte = tscn_pkg::tscn_hex(nib_mask);
		end else if (idx < `TSCN_IDX_LAST) begin
			frame_byte = tscn_pkg::tscn_hex(nib_csum);
		end else begin
			frame_byte = `TSCN_BYTE_CR;
		end
	end
endmodule : tscn_byte_sel

// ---- testbench/tscn_host_sink.sv ----
// host-side byte sink for the notifier, stalling at random
`timescale 1ns/100ps
module tscn_host_sink (
	input wire logic clk,
	input wire logic reset,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_stb,
	output logic [7:0] rx_byte
);
	// bytes are passed up whole; the bench compares them with the frame it builds from word, value and mask
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_ready <= 1'b0;
			rx_stb <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			rx_stb <= tx_valid & tx_ready;
			rx_byte <= tx_data;
			// stalls a quarter of cycles so held bytes get exercised
			tx_ready <= ($urandom % 4) != 0;
		end
	end
endmodule : tscn_host_sink

// ---- testbench/tb.sv ----
// self-checking bench for the change notifier
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb;
	logic clk = 0, reset = 1, ev_valid = 0, scr_change = 0, tx_ready;
	logic [15:0] ev_word = 0, ev_value = 0, ev_mask = 0, mom_word = 0, mom_value = 0;
	logic [15:0] mom_held = 0, mom_clr_word_q, mom_clr_mask_q, w, v, m;
	logic ev_ready_q, mom_clr_q, tx_valid_q, busy_q, rx_stb;
	logic [7:0] tx_data_q, rx_byte;
	logic [7:0] rx_q[$];
	int fails = 0, checked = 0;
	always #20 clk = ~clk;
	tscn_notifier uut (.clk(clk), .reset(reset), .ev_valid(ev_valid), .ev_word(ev_word),
		.ev_value(ev_value), .ev_mask(ev_mask), .ev_ready_q(ev_ready_q),
		.scr_change(scr_change), .mom_word(mom_word), .mom_value(mom_value),
		.mom_held(mom_held), .mom_clr_q(mom_clr_q), .mom_clr_word_q(mom_clr_word_q),
		.mom_clr_mask_q(mom_clr_mask_q), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
		.tx_ready(tx_ready), .busy_q(busy_q));
	tscn_host_sink host (.clk(clk), .reset(reset), .tx_valid(tx_valid_q),
		.tx_data(tx_data_q), .tx_ready(tx_ready), .rx_stb(rx_stb), .rx_byte(rx_byte));
	always @(posedge clk) if (rx_stb === 1'b1) rx_q.push_back(rx_byte);
	function automatic logic [7:0] asc(input logic [3:0] n);
		return (n < 4'ha) ? {4'h0, n} + 8'h30 : {4'h0, n} + 8'h37;
	endfunction : asc
	task automatic send_ev(input logic [15:0] wd, vl, mk);
		int n;
		n = 0;
		@(posedge clk);
		ev_valid <= 1'b1;
		ev_word <= wd;
		ev_value <= vl;
		ev_mask <= mk;
		do begin @(posedge clk); n++; end while (ev_ready_q !== 1'b1 && n < 3000);
		`CHK("ev taken", 1'b1, ev_ready_q)
		ev_valid <= 1'b0;
		@(posedge clk);
		`CHK("busy", mk != 0, busy_q)
	endtask : send_ev
	task automatic expect_frame(input logic [15:0] wd, vl, mk);
		logic [7:0] f[18];
		logic [15:0] fld[3];
		logic [7:0] s, b;
		int n;
		fld = '{wd, vl, mk};
		f[0] = 8'h1b;
		f[1] = 8'h53;
		f[2] = 8'h54;
		for (int i = 0; i < 12; i++) f[3 + i] = asc(4'(fld[i / 4] >> (12 - 4 * (i % 4))));
		s = 8'h00;
		for (int i = 0; i < 15; i++) s += f[i];
		f[15] = asc(s[7:4]);
		f[16] = asc(s[3:0]);
		f[17] = 8'h0d;
		n = 0;
		while (rx_q.size() < 18 && n < 3000) begin @(posedge clk); n++; end
		for (int i = 0; i < 18; i++) begin
			b = (rx_q.size() > 0) ? rx_q.pop_front() : 8'hxx;
			`CHK("frame byte", f[i], b)
		end
	endtask : expect_frame
	task automatic scr(input logic [15:0] wd, vl, hd);
		@(posedge clk);
		scr_change <= 1'b1;
		mom_word <= wd;
		mom_value <= vl;
		mom_held <= hd;
		@(posedge clk);
		scr_change <= 1'b0;
		@(posedge clk);
		`CHK("mom clear", (vl & hd) != 0, mom_clr_q)
		if ((vl & hd) != 0) begin
			`CHK("mom mask", vl & hd, mom_clr_mask_q)
			`CHK("mom word", wd, mom_clr_word_q)
			expect_frame(wd, vl & ~hd, vl & hd);
		end
	endtask : scr
	task automatic tally_and_finish;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#400000;
		fails++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(95));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		send_ev(16'h0102, 16'h3013, 16'h0001);
		expect_frame(16'h0102, 16'h3013, 16'h0001);
		send_ev(16'h0005, 16'h1234, 16'h0000);
		send_ev(16'hffff, 16'h0000, 16'h8000);
		send_ev(16'habcd, 16'hf0f0, 16'h00ff);
		expect_frame(16'hffff, 16'h0000, 16'h8000);
		expect_frame(16'habcd, 16'hf0f0, 16'h00ff);
		scr(16'h0200, 16'h00a5, 16'h0021);
		scr(16'h0201, 16'h00a5, 16'h0100);
		`CHK("stray bytes", 0, rx_q.size())
		for (int k = 0; k < 16; k++) begin
			w = 16'($urandom);
			v = 16'($urandom);
			m = ($urandom % 2) ? 16'h0001 << ($urandom % 16) : 16'($urandom) | 16'h0010;
			send_ev(w, v, m);
			expect_frame(w, v, m);
			if (k % 4 == 0) scr(w, v, m);
		end
		tally_and_finish();
	end
endmodule : tb
